// ===== design/pmgc_pkg.sv
package pmgc_pkg;
  // register byte offsets on the management slave
  localparam logic [7:0] PMGC_OFS_SHARE = 8'h00;
  localparam logic [7:0] PMGC_OFS_GROUP = 8'h04;
  localparam logic [7:0] PMGC_OFS_ILEAVE = 8'h08;
  localparam logic [7:0] PMGC_OFS_SEQ = 8'h0c;
  localparam logic [7:0] PMGC_OFS_CMD = 8'h10;
  localparam logic [7:0] PMGC_OFS_SECURE = 8'h14;
  localparam logic [7:0] PMGC_OFS_STATUS = 8'h18;
  localparam logic [7:0] PMGC_OFS_SNAPCTL = 8'h1c;
  localparam logic [7:0] PMGC_OFS_TLM = 8'h20;
  localparam logic [7:0] PMGC_OFS_SNAP = 8'h40;
  // command register bits
  localparam int PMGC_CMD_STORE = 0;
  localparam int PMGC_CMD_RESTORE = 1;
  localparam int PMGC_CMD_CLEAR = 2;
  // group_broadcast_config bits
  localparam int PMGC_GRP_BCAST = 0;
  localparam int PMGC_GRP_SPREAD = 1;
  localparam int PMGC_GRP_FOLLOW = 2;
  localparam int PMGC_GRP_RETRY = 3;
  // strap decode
  localparam logic [10:0] PMGC_STRAP_GND_MAX = 11'h032;
  localparam logic [10:0] PMGC_STRAP_OPEN_MIN = 11'h7d0;
  localparam int PMGC_STRAP_ENTRIES = 29;
  localparam logic PMGC_FOUR_UNIT_FW = 1'b1;
  // reset values, factory security level, store marker and word counts
  localparam logic [3:0] PMGC_GROUP_RST = 4'h0;
  localparam logic [3:0] PMGC_ILEAVE_RST = 4'h0;
  localparam logic [3:0] PMGC_HALF_TURN = 4'h8;
  localparam logic [11:0] PMGC_SEQ_RST = 12'h001;
  localparam logic [1:0] PMGC_SEC_RST = 2'h0;
  localparam logic [1:0] PMGC_SEC_FACTORY = 2'h3;
  localparam logic [15:0] PMGC_NVM_MARK = 16'h5a3c;
  localparam int PMGC_NVM_WORDS = 5;
  localparam int PMGC_TLM_WORDS = 7;
  localparam int PMGC_SNAP_WORDS = 8;
  // current share broadcast interval
  localparam int PMGC_SHARE_US = 10;
  localparam int PMGC_CLK_MHZ = 100;
  localparam logic [10:0] PMGC_SHARE_CYC = 11'(PMGC_SHARE_US * PMGC_CLK_MHZ);
  // inter_device_bus message types
  localparam logic [1:0] PMGC_MSG_FAULT = 2'h0;
  localparam logic [1:0] PMGC_MSG_SEQ_UP = 2'h1;
  localparam logic [1:0] PMGC_MSG_SEQ_DN = 2'h2;
  localparam logic [1:0] PMGC_MSG_SHARE = 2'h3;

  typedef enum logic [2:0] {
    PMGC_ST_OFF = 3'b000,
    PMGC_ST_WAIT_PREV = 3'b001,
    PMGC_ST_RAMP_UP = 3'b010,
    PMGC_ST_ON = 3'b011,
    PMGC_ST_WAIT_NEXT = 3'b100,
    PMGC_ST_RAMP_DN = 3'b101,
    PMGC_ST_FAULT = 3'b110
  } pmgc_state_t;
endpackage

// ===== design/pmgc_strap_dec.sv
`timescale 1ns/1ps
module pmgc_strap_dec (
  input wire logic [10:0] strap_dkohm_in,
  output logic [2:0] pos_out,
  output logic [2:0] cnt_out,
  output logic [4:0] droop_out,
  output logic soft_off_out
);
  // tabulated strap values in units of 0.1 kohm
  function automatic logic [10:0] rval(input int i);
    case (i)
      0: rval = 11'd100; 1: rval = 11'd110; 2: rval = 11'd121; 3: rval = 11'd133;
      4: rval = 11'd147; 5: rval = 11'd162; 6: rval = 11'd178; 7: rval = 11'd196;
      8: rval = 11'd215; 9: rval = 11'd237; 10: rval = 11'd261; 11: rval = 11'd287;
      12: rval = 11'd316; 13: rval = 11'd348; 14: rval = 11'd383; 15: rval = 11'd422;
      16: rval = 11'd464; 17: rval = 11'd511; 18: rval = 11'd562; 19: rval = 11'd619;
      20: rval = 11'd681; 21: rval = 11'd750; 22: rval = 11'd825; 23: rval = 11'd909;
      24: rval = 11'd1000; 25: rval = 11'd1100; 26: rval = 11'd1210; 27: rval = 11'd1330;
      default: rval = 11'd1470;
    endcase
  endfunction

  // entry: position, group size, droop in 0.01 mV/A
  function automatic logic [10:0] entry(input logic [4:0] i);
    case (i)
      5'd0: entry = {3'd1, 3'd2, 5'd7};  5'd1: entry = {3'd2, 3'd2, 5'd7};
      5'd2: entry = {3'd1, 3'd2, 5'd10}; 5'd3: entry = {3'd2, 3'd2, 5'd10};
      5'd4: entry = {3'd1, 3'd2, 5'd13}; 5'd5: entry = {3'd2, 3'd2, 5'd13};
      5'd6: entry = {3'd1, 3'd2, 5'd17}; 5'd7: entry = {3'd2, 3'd2, 5'd17};
      5'd8: entry = {3'd1, 3'd2, 5'd21}; 5'd9: entry = {3'd2, 3'd2, 5'd21};
      5'd10: entry = {3'd1, 3'd3, 5'd5}; 5'd11: entry = {3'd2, 3'd3, 5'd5};
      5'd12: entry = {3'd3, 3'd3, 5'd5}; 5'd13: entry = {3'd1, 3'd3, 5'd7};
      5'd14: entry = {3'd2, 3'd3, 5'd7}; 5'd15: entry = {3'd3, 3'd3, 5'd7};
      5'd16: entry = {3'd1, 3'd3, 5'd9}; 5'd17: entry = {3'd2, 3'd3, 5'd9};
      5'd18: entry = {3'd3, 3'd3, 5'd9}; 5'd19: entry = {3'd1, 3'd3, 5'd11};
      5'd20: entry = {3'd2, 3'd3, 5'd11}; 5'd21: entry = {3'd3, 3'd3, 5'd11};
      5'd22: entry = {3'd1, 3'd3, 5'd14}; 5'd23: entry = {3'd2, 3'd3, 5'd14};
      5'd24: entry = {3'd3, 3'd3, 5'd14}; 5'd25: entry = {3'd1, 3'd4, 5'd7};
      5'd26: entry = {3'd2, 3'd4, 5'd7}; 5'd27: entry = {3'd3, 3'd4, 5'd7};
      5'd28: entry = {3'd4, 3'd4, 5'd7};
      default: entry = {3'd1, 3'd1, 5'd0};
    endcase
  endfunction

  // nearest value: count the midpoints that the reading lies above
  logic [pmgc_pkg::PMGC_STRAP_ENTRIES-2:0] above;
  genvar g;
  generate
    for (g = 0; g < pmgc_pkg::PMGC_STRAP_ENTRIES - 1; g++)
    begin : g_mid
      wire [11:0] mid2 = {1'b0, rval(g)} + {1'b0, rval(g + 1)};
      assign above[g] = {strap_dkohm_in, 1'b0} >= mid2;
    end
  endgenerate

  logic [4:0] idx;
  always_comb
  begin
    idx = 5'd0;
    for (int i = 0; i < pmgc_pkg::PMGC_STRAP_ENTRIES - 1; i++)
      idx = idx + 5'(above[i]);
  end

  // four-unit entries fall back to stand-alone on builds without them
  wire gnd = strap_dkohm_in <= pmgc_pkg::PMGC_STRAP_GND_MAX; // see (RL1)
  wire open_pin = strap_dkohm_in >= pmgc_pkg::PMGC_STRAP_OPEN_MIN; // see (RL2)
  wire no_four = !pmgc_pkg::PMGC_FOUR_UNIT_FW && idx >= 5'd25; // see (RL3)
  wire [10:0] ent = (gnd || open_pin || no_four) ? entry(5'h1f) : entry(idx); // see (RL3)
  assign pos_out = ent[10:8];
  assign cnt_out = ent[7:5];
  assign droop_out = ent[4:0];
  assign soft_off_out = !gnd;
endmodule

// ===== design/pmgc_top.sv
// Summary of operation
// (RL1) strap grounded: stand-alone, no droop, immediate off
// (RL2) strap open: stand-alone, no droop, soft off
// (RL3) strap decodes clock role, position, size, droop
// (RL4) no retry when sharing or spreading faults
// (RL5) phase offset 0-337.5 in 22.5 degree steps
// (RL6) internal phases default 180 degrees apart
// (RL7) offset applied only once locked to shared clock
// (RL8) broadcast and spread on: fault shuts down, sends event
// (RL9) follower shuts down on received fault event
// (RL10) preceding and following ids order power sequencing
// (RL11) shared enable starts ordered turn-on and turn-off
// (RL12) system should enable fault broadcast in groups
// (RL13) telemetry readable over management bus
// (RL14) fault captures snapshot, readable under control
// (RL15) initialisation loads stored settings if present
// (RL16) store command writes settings to nonvolatile memory
// (RL17) restore limited to the user's security level
// (RL18) lowest position is reference, broadcasts its current
// (RL19) group commands propagate only with broadcast enabled
// (RL20) strap sampled once after reset, latched, overridable
`timescale 1ns/1ps
module pmgc_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [10:0] strap_dkohm_in,
  input wire logic enable_in,
  input wire logic fault_in,
  input wire logic power_good_in,
  input wire logic sync_locked_in,
  input wire logic [15:0] tlm_vin_in,
  input wire logic [15:0] tlm_vout_in,
  input wire logic [15:0] tlm_iout_in,
  input wire logic [15:0] tlm_temp_in,
  input wire logic [15:0] tlm_duty_in,
  input wire logic [15:0] tlm_freq_in,
  input wire logic [15:0] tlm_vmon_in,
  input wire logic idb_rx_valid_in,
  input wire logic [1:0] idb_rx_type_in,
  input wire logic [15:0] idb_rx_data_in,
  output logic idb_tx_valid_out,
  output logic [1:0] idb_tx_type_out,
  output logic [15:0] idb_tx_data_out,
  input wire logic idb_tx_ready_in,
  output logic power_en_out,
  output logic soft_off_out,
  output logic sync_drive_out,
  output logic [3:0] phase_a_out,
  output logic [3:0] phase_b_out,
  output logic retry_en_out,
  output logic [4:0] load_line_slope_out,
  output logic [20:0] vtrim_out,
  output logic shutdown_out
);
  // share_position_config: pos, group size, droop, soft-off
  logic [11:0] share_r;
  logic [3:0] group_r;
  logic [3:0] ileave_r;
  logic [11:0] seq_r;
  logic [1:0] sec_r;
  logic snap_arm_r;
  logic strap_done_r;
  logic ack_r;
  logic fault_latch_r;
  logic follow_latch_r;
  logic [15:0] ref_cur_r;
  logic [10:0] share_cnt_r;
  logic pend_fault_r;
  logic pend_up_r;
  logic pend_dn_r;
  logic pend_share_r;
  logic nvm_init_r;
  logic [1:0] nvm_lvl_r;
  logic [15:0] nvm_r [0:pmgc_pkg::PMGC_NVM_WORDS-1];
  logic [15:0] snap_r [0:pmgc_pkg::PMGC_SNAP_WORDS-1];
  pmgc_pkg::pmgc_state_t st_r;
  pmgc_pkg::pmgc_state_t st_nxt;

  wire [2:0] dec_pos;
  wire [2:0] dec_cnt;
  wire [4:0] dec_droop;
  wire dec_soft;

  pmgc_strap_dec pmgc_strap_dec_i (
    .strap_dkohm_in(strap_dkohm_in),
    .pos_out(dec_pos),
    .cnt_out(dec_cnt),
    .droop_out(dec_droop),
    .soft_off_out(dec_soft)
  );

  // field views
  wire [2:0] my_pos = share_r[2:0];
  wire [2:0] grp_cnt = share_r[5:3];
  wire [4:0] droop = share_r[10:6];
  wire sharing = grp_cnt > 3'd1;
  wire bcast = group_r[pmgc_pkg::PMGC_GRP_BCAST];
  wire spread = group_r[pmgc_pkg::PMGC_GRP_SPREAD];
  wire follow = group_r[pmgc_pkg::PMGC_GRP_FOLLOW];
  wire [3:0] my_id = seq_r[3:0];
  wire [3:0] prev_id = seq_r[7:4];
  wire [3:0] next_id = seq_r[11:8];

  // bus decode: the write lands on the edge where waitrequest is seen low
  wire req = avs_read_in || avs_write_in;
  wire wr_go = ack_r && avs_write_in;
  wire [31:0] wd = avs_writedata_in;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction
  wire wr_share = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_SHARE);
  wire wr_group = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_GROUP);
  wire wr_ileave = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_ILEAVE);
  wire wr_seq = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_SEQ);
  wire wr_cmd = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_CMD);
  wire wr_sec = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_SECURE);
  wire wr_snapctl = wr_go && hit(avs_address_in, pmgc_pkg::PMGC_OFS_SNAPCTL);
  wire cmd_store = wr_cmd && wd[pmgc_pkg::PMGC_CMD_STORE];
  wire cmd_restore = wr_cmd && wd[pmgc_pkg::PMGC_CMD_RESTORE];
  wire cmd_clear = wr_cmd && wd[pmgc_pkg::PMGC_CMD_CLEAR];

  // telemetry and snapshot read windows
  wire [15:0] tlm [0:pmgc_pkg::PMGC_TLM_WORDS-1];
  assign tlm[0] = tlm_vin_in;
  assign tlm[1] = tlm_vout_in;
  assign tlm[2] = tlm_iout_in;
  assign tlm[3] = tlm_temp_in;
  assign tlm[4] = tlm_duty_in;
  assign tlm[5] = tlm_freq_in;
  assign tlm[6] = tlm_vmon_in; // aux_monitor_read
  wire [7:0] tlm_ofs = avs_address_in - pmgc_pkg::PMGC_OFS_TLM;
  wire [7:0] snap_ofs = avs_address_in - pmgc_pkg::PMGC_OFS_SNAP;
  wire tlm_hit = avs_address_in >= pmgc_pkg::PMGC_OFS_TLM && tlm_ofs[7:2] < 6'd7
    && tlm_ofs[1:0] == 2'd0;
  wire snap_hit = avs_address_in >= pmgc_pkg::PMGC_OFS_SNAP && snap_ofs[7:2] < 6'd8
    && snap_ofs[1:0] == 2'd0;
  wire [31:0] status = {21'h0, pend_fault_r, follow_latch_r, fault_latch_r,
    sync_locked_in, my_pos == 3'd1 && sharing, nvm_init_r, st_r, shutdown_out, power_en_out};

  // read mux; unmapped words read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (avs_address_in)
      pmgc_pkg::PMGC_OFS_SHARE: rd_mux = {20'h0, share_r};
      pmgc_pkg::PMGC_OFS_GROUP: rd_mux = {28'h0, group_r};
      pmgc_pkg::PMGC_OFS_ILEAVE: rd_mux = {28'h0, ileave_r};
      pmgc_pkg::PMGC_OFS_SEQ: rd_mux = {20'h0, seq_r};
      pmgc_pkg::PMGC_OFS_SECURE: rd_mux = {28'h0, nvm_lvl_r, sec_r};
      pmgc_pkg::PMGC_OFS_STATUS: rd_mux = status;
      pmgc_pkg::PMGC_OFS_SNAPCTL: rd_mux = {31'h0, snap_arm_r};
      default:
        if (tlm_hit)
          rd_mux = {16'h0, tlm[tlm_ofs[4:2]]}; // see (RL13)
        else if (snap_hit && !snap_arm_r)
          rd_mux = {16'h0, snap_r[snap_ofs[4:2]]}; // see (RL14)
        else
          rd_mux = 32'h0;
    endcase
  end

  // one wait state, then the answer; keeps the mux off the bus-return path
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      ack_r <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0;
    end
    else if (ce_in)
    begin
      ack_r <= req && !ack_r;
      avs_waitrequest_out <= !(req && !ack_r);
      if (req && !ack_r)
        avs_readdata_out <= rd_mux;
    end
  end

  // received group messages; sequencing steps only honoured with broadcast on, fault and share messages always
  wire rx_fault = idb_rx_valid_in && idb_rx_type_in == pmgc_pkg::PMGC_MSG_FAULT;
  wire rx_up = bcast && idb_rx_valid_in && idb_rx_type_in == pmgc_pkg::PMGC_MSG_SEQ_UP
    && idb_rx_data_in[3:0] == prev_id; // see (RL19)
  wire rx_dn = bcast && idb_rx_valid_in && idb_rx_type_in == pmgc_pkg::PMGC_MSG_SEQ_DN
    && idb_rx_data_in[3:0] == next_id; // see (RL19)
  wire rx_share = idb_rx_valid_in && idb_rx_type_in == pmgc_pkg::PMGC_MSG_SHARE;
  wire own_fault = fault_in && st_r != pmgc_pkg::PMGC_ST_FAULT;
  wire fol_fault = follow && rx_fault && st_r != pmgc_pkg::PMGC_ST_FAULT; // see (RL9)
  wire trip = own_fault || fol_fault;
  wire retry_ok = group_r[pmgc_pkg::PMGC_GRP_RETRY] && !sharing && !spread; // see (RL4)

  // sequencing: without broadcast or a neighbour id the step is not waited on
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      pmgc_pkg::PMGC_ST_OFF:
        if (enable_in)
          st_nxt = pmgc_pkg::PMGC_ST_WAIT_PREV; // see (RL11)
      pmgc_pkg::PMGC_ST_WAIT_PREV:
        if (!enable_in)
          st_nxt = pmgc_pkg::PMGC_ST_OFF;
        else if (prev_id == 4'h0 || !bcast || rx_up)
          st_nxt = pmgc_pkg::PMGC_ST_RAMP_UP; // see (RL10)
      pmgc_pkg::PMGC_ST_RAMP_UP:
        if (!enable_in)
          st_nxt = pmgc_pkg::PMGC_ST_WAIT_NEXT;
        else if (power_good_in)
          st_nxt = pmgc_pkg::PMGC_ST_ON;
      pmgc_pkg::PMGC_ST_ON:
        if (!enable_in)
          st_nxt = pmgc_pkg::PMGC_ST_WAIT_NEXT; // see (RL11)
      pmgc_pkg::PMGC_ST_WAIT_NEXT:
        if (next_id == 4'h0 || !bcast || rx_dn)
          st_nxt = pmgc_pkg::PMGC_ST_RAMP_DN; // see (RL10)
      pmgc_pkg::PMGC_ST_RAMP_DN:
        if (!power_good_in)
          st_nxt = pmgc_pkg::PMGC_ST_OFF;
      pmgc_pkg::PMGC_ST_FAULT:
        if (cmd_clear || retry_ok)
          st_nxt = pmgc_pkg::PMGC_ST_OFF; // see (RL4)
      default:
        st_nxt = pmgc_pkg::PMGC_ST_OFF;
    endcase
    if (trip)
      st_nxt = pmgc_pkg::PMGC_ST_FAULT; // see (RL8)
  end

  wire up_done = st_r == pmgc_pkg::PMGC_ST_RAMP_UP && st_nxt == pmgc_pkg::PMGC_ST_ON;
  wire dn_done = st_r == pmgc_pkg::PMGC_ST_RAMP_DN && st_nxt == pmgc_pkg::PMGC_ST_OFF;
  wire on_now = st_nxt == pmgc_pkg::PMGC_ST_RAMP_UP || st_nxt == pmgc_pkg::PMGC_ST_ON;
  wire is_ref = sharing && my_pos == 3'd1; // see (RL18)
  wire share_tick = is_ref && bcast && power_en_out
    && share_cnt_r == pmgc_pkg::PMGC_SHARE_CYC - 11'd1;

  // transmit arbitration: fault first, then sequencing, then sharing
  wire tx_free = !idb_tx_valid_out || idb_tx_ready_in;
  wire send_fault = tx_free && pend_fault_r;
  wire send_up = tx_free && !pend_fault_r && pend_up_r;
  wire send_dn = tx_free && !pend_fault_r && !pend_up_r && pend_dn_r;
  wire send_share = tx_free && !pend_fault_r && !pend_up_r && !pend_dn_r && pend_share_r;

  // sequence, fault latches and message queue; a new event beats its own clear
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= pmgc_pkg::PMGC_ST_OFF;
      fault_latch_r <= 1'b0;
      follow_latch_r <= 1'b0;
      pend_fault_r <= 1'b0;
      pend_up_r <= 1'b0;
      pend_dn_r <= 1'b0;
      pend_share_r <= 1'b0;
      share_cnt_r <= 11'h0;
    end
    else if (ce_in)
    begin
      st_r <= st_nxt;
      fault_latch_r <= own_fault || (fault_latch_r && !cmd_clear);
      follow_latch_r <= fol_fault || (follow_latch_r && !cmd_clear);
      pend_fault_r <= (own_fault && spread && bcast) || (pend_fault_r && !send_fault); // see (RL8)
      pend_up_r <= (up_done && bcast) || (pend_up_r && !send_up); // see (RL10)
      pend_dn_r <= (dn_done && bcast) || (pend_dn_r && !send_dn); // see (RL10)
      pend_share_r <= share_tick || (pend_share_r && !send_share); // see (RL18)
      share_cnt_r <= (share_tick || !power_en_out) ? 11'h0 : share_cnt_r + 11'd1;
    end
  end

  // inter_device_bus transmit register, held until the bus takes it
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      idb_tx_valid_out <= 1'b0;
      idb_tx_type_out <= pmgc_pkg::PMGC_MSG_FAULT;
      idb_tx_data_out <= 16'h0;
    end
    else if (ce_in && tx_free)
    begin
      idb_tx_valid_out <= pend_fault_r || pend_up_r || pend_dn_r || pend_share_r;
      idb_tx_type_out <= send_fault ? pmgc_pkg::PMGC_MSG_FAULT :
        send_up ? pmgc_pkg::PMGC_MSG_SEQ_UP :
        send_dn ? pmgc_pkg::PMGC_MSG_SEQ_DN : pmgc_pkg::PMGC_MSG_SHARE;
      idb_tx_data_out <= send_share ? tlm_iout_in : {12'h0, my_id}; // see (RL18)
    end
  end

  // members trim toward the reference current along the load line
  wire signed [16:0] cur_diff = $signed({1'b0, ref_cur_r}) - $signed({1'b0, tlm_iout_in});
  wire signed [20:0] trim = 21'(cur_diff * $signed({1'b0, droop}));

  // power stage and clocking outputs, all registered
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      power_en_out <= 1'b0;
      shutdown_out <= 1'b0;
      soft_off_out <= 1'b0;
      sync_drive_out <= 1'b0;
      phase_a_out <= pmgc_pkg::PMGC_ILEAVE_RST;
      phase_b_out <= pmgc_pkg::PMGC_HALF_TURN;
      retry_en_out <= 1'b0;
      load_line_slope_out <= 5'h0;
      vtrim_out <= 21'h0;
      ref_cur_r <= 16'h0;
    end
    else if (ce_in)
    begin
      power_en_out <= on_now;
      shutdown_out <= st_nxt == pmgc_pkg::PMGC_ST_FAULT; // see (RL9)
      soft_off_out <= share_r[11] && !trip; // see (RL1) (RL2)
      sync_drive_out <= sharing && my_pos == 3'd1; // see (RL3)
      if (sync_locked_in)
      begin
        phase_a_out <= ileave_r; // see (RL5) (RL7)
        phase_b_out <= ileave_r + pmgc_pkg::PMGC_HALF_TURN; // see (RL6)
      end
      retry_en_out <= retry_ok;
      load_line_slope_out <= droop;
      if (rx_share && sharing && !is_ref)
        ref_cur_r <= idb_rx_data_in;
      vtrim_out <= (sharing && !is_ref) ? trim : 21'h0; // see (RL18)
    end
  end

  // configuration: strap once, then stored copy, host writes and restores
  wire nvm_ok = nvm_r[0] == pmgc_pkg::PMGC_NVM_MARK;
  wire rest_ok = cmd_restore && nvm_ok && nvm_lvl_r <= sec_r; // see (RL17)
  wire load_nvm = (strap_done_r && !nvm_init_r && nvm_ok) || rest_ok;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      strap_done_r <= 1'b0;
      nvm_init_r <= 1'b0;
      share_r <= 12'h0;
      group_r <= pmgc_pkg::PMGC_GROUP_RST;
      ileave_r <= pmgc_pkg::PMGC_ILEAVE_RST;
      seq_r <= pmgc_pkg::PMGC_SEQ_RST;
      sec_r <= pmgc_pkg::PMGC_SEC_RST;
      snap_arm_r <= 1'b1;
    end
    else if (ce_in)
    begin
      strap_done_r <= 1'b1;
      if (!strap_done_r)
        share_r <= {dec_soft, dec_droop, dec_cnt, dec_pos}; // see (RL20) (RL3)
      nvm_init_r <= strap_done_r;
      if (load_nvm)
      begin
        share_r <= nvm_r[1][11:0]; // see (RL15)
        group_r <= nvm_r[2][3:0];
        ileave_r <= nvm_r[3][3:0];
        seq_r <= nvm_r[4][11:0];
      end
      else if (strap_done_r)
      begin
        if (wr_share)
          share_r <= wd[11:0]; // see (RL20)
        if (wr_group)
          group_r <= wd[3:0]; // see (RL19)
        if (wr_ileave)
          ileave_r <= wd[3:0]; // see (RL5)
        if (wr_seq)
          seq_r <= wd[11:0]; // see (RL10)
      end
      if (wr_sec)
        sec_r <= wd[1:0];
      if (wr_snapctl)
        snap_arm_r <= wd[0];
    end
  end

  // nonvolatile store keeps its contents across reset on purpose
  always_ff @(posedge clk_in)
  begin
    if (ce_in && cmd_store)
    begin
      nvm_r[0] <= pmgc_pkg::PMGC_NVM_MARK; // see (RL16)
      nvm_r[1] <= {4'h0, share_r};
      nvm_r[2] <= {12'h0, group_r};
      nvm_r[3] <= {12'h0, ileave_r};
      nvm_r[4] <= {4'h0, seq_r};
      nvm_lvl_r <= sec_r; // see (RL17)
    end
  end

  // snapshot of telemetry and fault status on the trip, if armed
  genvar s;
  generate
    for (s = 0; s < pmgc_pkg::PMGC_SNAP_WORDS; s++)
    begin : g_snap
      always_ff @(posedge clk_in)
      begin
        if (!reset_n_in)
          snap_r[s] <= 16'h0;
        else if (ce_in && trip && snap_arm_r)
          snap_r[s] <= (s < pmgc_pkg::PMGC_TLM_WORDS) ? tlm[s % pmgc_pkg::PMGC_TLM_WORDS]
            : {14'h0, fol_fault, own_fault};
      end
    end
  endgenerate
endmodule

// ===== testbench/pmgc_props.sv
`timescale 1ns/1ps
// port-level checks: bus wait state, phase pairing, fault and tx rules
module pmgc_props (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic sync_locked_in,
  input wire logic [3:0] phase_a_out,
  input wire logic [3:0] phase_b_out,
  input wire logic retry_en_out,
  input wire logic [4:0] load_line_slope_out,
  input wire logic idb_tx_valid_out,
  input wire logic idb_tx_ready_in,
  input wire logic [1:0] idb_tx_type_out,
  input wire logic [15:0] idb_tx_data_out,
  input wire logic shutdown_out,
  input wire logic power_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence s_ack; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
  property p_one_wait; s_req |=> s_ack; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state");
  property p_idle; !(avs_read_in || avs_write_in) |=> avs_waitrequest_out; endproperty
  a_idle: assert property (p_idle) else $error("idle ack");
  property p_pair; phase_b_out == phase_a_out + 4'h8; endproperty
  a_pair: assert property (p_pair) else $error("phase pair");
  property p_lock; !sync_locked_in |=> $stable(phase_a_out); endproperty
  a_lock: assert property (p_lock) else $error("phase unlocked");
  // retry is only legal for a stand-alone unit, which has no droop
  property p_retry; retry_en_out |-> load_line_slope_out == 5'h00; endproperty
  a_retry: assert property (p_retry) else $error("retry shared");
  property p_hold; idb_tx_valid_out && !idb_tx_ready_in |=> idb_tx_valid_out
    && $stable(idb_tx_type_out) && $stable(idb_tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("tx hold");
  property p_ftx; idb_tx_valid_out && idb_tx_type_out == 2'h0 |-> shutdown_out; endproperty
  a_ftx: assert property (p_ftx) else $error("fault tx");
  property p_trip; $rose(shutdown_out) |-> ##[0:2] !power_en_out; endproperty
  a_trip: assert property (p_trip) else $error("trip power");
endmodule
bind pmgc_top pmgc_props pmgc_props_i (.*);

// ===== testbench/pmgc_peer.sv
`timescale 1ns/1ps
// peer unit: may stall our tx, broadcasts a fault on request
module pmgc_peer (
  input wire logic clk_in,
  input wire logic peer_send,
  input wire logic peer_stall,
  output logic idb_tx_ready_in = 1'b0,
  output logic idb_rx_valid_in = 1'b0,
  output logic [1:0] idb_rx_type_in = 2'h3,
  output logic [15:0] idb_rx_data_in = 16'h0
);
  logic [15:0] junk_r = 16'h1;
  // idle fields churn so nothing can lean on stale values
  always_ff @(posedge clk_in)
  begin
    junk_r <= junk_r + 16'h3b1;
    idb_tx_ready_in <= !peer_stall;
    idb_rx_valid_in <= peer_send;
    idb_rx_type_in <= peer_send ? pmgc_pkg::PMGC_MSG_FAULT : junk_r[1:0];
    idb_rx_data_in <= peer_send ? 16'h0002 : junk_r;
  end
endmodule

// ===== testbench/test_pmgc_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
`define WAITU(c) begin n = 0; while (!(c) && n < 99) begin @(posedge clk_in); n++; end end
module test_pmgc_top;
  logic clk_in = 0, reset_n_in = 0, ce_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic [7:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, enable_in = 0, fault_in = 0, power_good_in = 0;
  logic sync_locked_in = 0, peer_send = 0, peer_stall = 0, power_en_out, soft_off_out;
  logic [10:0] strap_dkohm_in = 11'h000;
  logic [15:0] tlm_vin_in, tlm_vout_in, tlm_iout_in, tlm_temp_in;
  logic [15:0] tlm_duty_in, tlm_freq_in, tlm_vmon_in, idb_rx_data_in, idb_tx_data_out;
  logic idb_rx_valid_in, idb_tx_valid_out, idb_tx_ready_in, sync_drive_out;
  logic [1:0] idb_rx_type_in, idb_tx_type_out;
  logic retry_en_out, shutdown_out;
  logic [3:0] phase_a_out, phase_b_out;
  logic [4:0] load_line_slope_out;
  logic [20:0] vtrim_out;
  logic [63:0] expq [$];
  logic [63:0] ent;
  int num_errors = 0, n_compared = 0, cyc = 0;
  pmgc_top pmgc_top_i (.*);
  pmgc_peer pmgc_peer_i (.*);
  always #5 clk_in = !clk_in;
  task automatic complete_run;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    expq.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic do_reset(input logic [10:0] s);
    reset_n_in <= 1'b0;
    strap_dkohm_in <= s;
    repeat (12) @(posedge clk_in);
    `CHK(phase_b_out, 4'h8)
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask
  // read data is judged at the accepting edge against the oldest note
  always @(posedge clk_in)
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
    begin
      ent = expq.pop_front();
      `CHK(avs_readdata_out & ent[63:32], ent[31:0])
    end
  // hang guard, far above the expected run length
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    logic [10:0] straps [3];
    logic [31:0] shares [3];
    logic [15:0] t [7];
    logic [3:0] v;
    int n;
    straps = '{11'h000, 11'h7ff, 11'h064};
    shares = '{32'h009, 32'h809, 32'h1d1};
    void'($urandom(28601));
    foreach (t[k]) t[k] = 16'($urandom);
    {tlm_vin_in, tlm_vout_in, tlm_iout_in, tlm_temp_in} <= {t[0], t[1], t[2], t[3]};
    {tlm_duty_in, tlm_freq_in, tlm_vmon_in} <= {t[4], t[5], t[6]};
    for (int i = 0; i < 3; i++)
    begin
      do_reset(straps[i]);
      rd(8'h00, shares[i], i == 2 ? 32'h7ff : '1);
      `CHK(load_line_slope_out, i == 2 ? 5'h07 : 5'h00)
      `CHK(sync_drive_out, i == 2)
      `CHK(soft_off_out, i != 0)
      `CHK(vtrim_out, 21'h0)
      bus(1'b1, 8'h04, 32'h8);
      repeat (3) @(posedge clk_in);
      `CHK(retry_en_out, i != 2)
    end
    v = 4'($urandom);
    bus(1'b1, 8'h08, {28'h0, v});
    repeat (3) @(posedge clk_in);
    `CHK(phase_a_out, 4'h0)
    sync_locked_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK(phase_a_out, v)
    for (int k = 0; k < 7; k++)
      rd(8'(32 + 4 * k), {16'h0, t[k]});
    rd(8'hfc, 32'h0);
    bus(1'b1, 8'h04, 32'h3);
    enable_in <= 1'b1;
    power_good_in <= 1'b1;
    `WAITU(power_en_out === 1'b1)
    `CHK(power_en_out, 1'b1)
    repeat (6) @(posedge clk_in);
    peer_stall <= 1'b1;
    fault_in <= 1'b1;
    @(posedge clk_in);
    fault_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK({shutdown_out, idb_tx_valid_out, idb_tx_type_out, idb_tx_data_out}, 20'hc0001)
    peer_stall <= 1'b0;
    bus(1'b1, 8'h1c, 32'h0);
    rd(8'h40, {16'h0, t[0]});
    rd(8'h5c, 32'h1, 32'h3);
    bus(1'b1, 8'h10, 32'h4);
    bus(1'b1, 8'h04, 32'h4);
    `CHK(shutdown_out, 1'b0)
    peer_send <= 1'b1;
    @(posedge clk_in);
    peer_send <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK(shutdown_out, 1'b1)
    bus(1'b1, 8'h10, 32'h1);
    repeat (4) @(posedge clk_in);
    do_reset(11'h064);
    rd(8'h08, {28'h0, v});
    complete_run();
  end
endmodule
